// ### include/flash_operand_pkg.sv
// package of offsets, field positions and reset values for the flash operand block
// assumes a 32-bit classic wishbone slave, one aligned word per register
package flash_operand_pkg;
	// register indexes (printed offsets are not all multiples of four)
	localparam logic [19:0] IDX_DATA_LO  = 20'h8_000c;
	localparam logic [19:0] IDX_DATA_HI  = 20'h8_000e;
	localparam logic [19:0] IDX_LOC_LO   = 20'h8_0010;
	localparam logic [19:0] IDX_LOC_HI   = 20'h8_0012;
	localparam logic [19:0] IDX_FAULT    = 20'h8_0014;
	localparam logic [19:0] IDX_IRQ_STAT = 20'h8_0016;
	localparam logic [19:0] IDX_IRQ_MASK = 20'h8_0018;
	localparam logic [19:0] IDX_STATUS   = 20'h8_001a;
	localparam logic [19:0] IDX_PROT0    = 20'h8_001c;
	// reset values
	localparam logic [15:0] RST_DATA     = 16'hffff;
	localparam logic [15:0] RST_LOC      = 16'h0000;
	localparam logic [15:0] RST_FAULT    = 16'h0000;
	localparam logic [15:0] PROT_ACTIVE  = 16'h0000;
	// address field layout
	localparam int LOC_LO_MSB = 15;
	localparam int LOC_LO_LSB = 2;
	localparam int LOC_HI_MSB = 4;
	// fault register field positions
	localparam int F_WRITE    = 0;
	localparam int F_ERASE    = 1;
	localparam int F_PROGRAM  = 2;
	localparam int F_ONEZERO  = 3;
	localparam int F_SEQUENCE = 4;
	localparam int F_RESUME   = 5;
	localparam int F_PROTECT  = 6;
	localparam int F_COUNT    = 7;
	// status register field positions
	localparam int S_HOLD     = 0;
	localparam int S_BUSY     = 1;
	localparam int S_LOADED   = 2;
	localparam int S_OPVALID  = 3;
	// number of volatile protection copies
	localparam int PROT_REGS  = 4;
endpackage : flash_operand_pkg

// ### logic/flash_program_operand_and_error_regs.sv
// operand, fault and protection-shadow registers of the flash write sequencer
// assumes the engine reports faults as pulses and the nv array is read by a handshake
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ps
module flash_program_operand_and_error_regs
	import flash_operand_pkg::*;
#(
	parameter int SECTORS = 8
) (
	// clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [21:0]          wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic      [31:0]          wb_dat_o,
	output logic                      wb_ack_o,
	// flash engine status and events
	input  wire logic                 access_hold_i,
	input  wire logic                 bank0_busy_flag_i,
	input  wire logic                 start_i,
	input  wire logic                 op_is_protect_i,
	input  wire logic                 exec_from_flash_i,
	input  wire logic                 setup_bad_i,
	input  wire logic                 ev_erase_fail_i,
	input  wire logic                 ev_program_fail_i,
	input  wire logic                 ev_one_over_zero_i,
	input  wire logic                 ev_resume_bad_i,
	input  wire logic                 ev_protected_i,
	input  wire logic [SECTORS-1:0]   erase_sel_i,
	// operands to the engine
	output logic      [31:0]          program_data_o,
	output logic      [20:0]          program_location_o,
	output logic                      start_accept_o,
	output logic                      abort_o,
	output logic      [SECTORS-1:0]   erase_enable_o,
	output logic      [SECTORS-1:0]   bank0_sector_status_o,
	// nv protection load port
	output logic                      nv_req_o,
	output logic      [1:0]           nv_idx_o,
	input  wire logic                 nv_ack_i,
	input  wire logic [15:0]          nv_data_i,
	output logic      [15:0]          write_protect_o,
	output logic                      prot_loaded_o,
	// interrupt
	output logic                      irq_o
);
	initial begin
		if (SECTORS < 1 || SECTORS > 16) $error("SECTORS must be 1..16");
	end

	// protection loader states
	typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_DONE} load_state_type;

	// storage
	logic [15:0]         data_lo_reg;       // low half of word to program
	logic [15:0]         data_hi_reg;       // high half
	logic [15:0]         loc_lo_reg;        // address 15:2, bits 1:0 kept zero
	logic [15:0]         loc_hi_reg;        // address 20:16 in bits 4:0
	logic [F_COUNT-1:0]  fault_reg;         // sticky fault flags
	logic [F_COUNT-1:0]  pend_reg;          // faults seen while busy
	logic [F_COUNT-1:0]  irq_stat_reg;      // sticky interrupt status
	logic [F_COUNT-1:0]  irq_mask_reg;      // interrupt enables
	logic [SECTORS-1:0]  sector_reg;        // bank0 sector status
	logic                busy_d_reg;        // busy of previous cycle
	logic                ack_reg;           // wishbone ack
	logic [31:0]         rdata_reg;         // wishbone read data
	logic [15:0]         prot_reg [PROT_REGS]; // volatile protection copies
	logic [1:0]          ld_idx_reg;        // which copy is loading
	load_state_type      ld_state_reg;      // loader state

	// bus decode
	wire         req        = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire  [19:0] idx        = wb_adr_i[21:2];
	wire         wr         = req & wb_we_i;
	wire         lanes_lo   = wb_sel_i[0] & wb_sel_i[1];
	wire         hit_dlo    = idx == IDX_DATA_LO;
	wire         hit_dhi    = idx == IDX_DATA_HI;
	wire         hit_llo    = idx == IDX_LOC_LO;
	wire         hit_lhi    = idx == IDX_LOC_HI;
	wire         hit_flt    = idx == IDX_FAULT;
	wire         hit_ist    = idx == IDX_IRQ_STAT;
	wire         hit_imk    = idx == IDX_IRQ_MASK;
	wire         hit_sts    = idx == IDX_STATUS;
	wire         hit_prot   = idx[19:2] == IDX_PROT0[19:2];
	wire         wr_ok      = wr & lanes_lo;

	// busy falling edge closes an operation
	wire         busy_fall  = busy_d_reg & ~bank0_busy_flag_i;

	// start acceptance: protection setting refused while executing from flash
	wire         prot_refuse = op_is_protect_i & exec_from_flash_i;
	wire         seq_bad     = start_i & (setup_bad_i | prot_refuse);
	assign start_accept_o    = start_i & ~setup_bad_i & ~prot_refuse & prot_loaded_o;

	// fault events of this cycle
	wire [F_COUNT-1:0] ev;
	assign ev[F_ERASE]    = ev_erase_fail_i;
	assign ev[F_PROGRAM]  = ev_program_fail_i;
	assign ev[F_ONEZERO]  = ev_one_over_zero_i & ~op_is_protect_i;
	assign ev[F_SEQUENCE] = seq_bad;
	assign ev[F_RESUME]   = ev_resume_bad_i;
	assign ev[F_PROTECT]  = ev_protected_i;
	assign ev[F_WRITE]    = |ev[F_COUNT-1:1];
	assign abort_o        = ev_resume_bad_i;

	// faults collect while busy and publish at busy release; faults outside busy are immediate
	wire [F_COUNT-1:0] pend_all = pend_reg | ev;
	wire [F_COUNT-1:0] publish  = busy_fall ? pend_all
		: (bank0_busy_flag_i ? '0 : ev);
	// write zero clears, write one keeps; a publish in the same cycle wins
	wire [F_COUNT-1:0] clr_mask = (wr_ok & hit_flt) ? ~wb_dat_i[F_COUNT-1:0] : '0;
	wire [F_COUNT-1:0] fault_next = (fault_reg & ~clr_mask) | publish;
	wire [F_COUNT-1:0] pend_next  = bank0_busy_flag_i ? pend_all : '0;
	// interrupt status: new publishes set, write one clears
	wire [F_COUNT-1:0] ist_clr  = (wr_ok & hit_ist) ? wb_dat_i[F_COUNT-1:0] : '0;
	wire [F_COUNT-1:0] ist_next = (irq_stat_reg & ~ist_clr) | publish;
	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// sector status: engine marks during busy, clean finish clears
	wire clean_end = busy_fall & ~pend_all[F_WRITE];
	wire [SECTORS-1:0] sector_next = clean_end ? '0
		: (bank0_busy_flag_i ? (sector_reg | erase_sel_i) : sector_reg);
	assign bank0_sector_status_o = sector_reg;

	// protected sectors are skipped in an erase; pre-load all protected
	assign write_protect_o = prot_reg[0];
	assign erase_enable_o  = erase_sel_i & prot_reg[0][SECTORS-1:0];

	// operands
	assign program_data_o     = {data_hi_reg, data_lo_reg};
	assign program_location_o = {loc_hi_reg[LOC_HI_MSB:0], loc_lo_reg[LOC_LO_MSB:LOC_LO_LSB],
		2'b00};

	// loader handshake
	assign nv_req_o      = ld_state_reg == LD_REQ;
	assign nv_idx_o      = ld_idx_reg;
	assign prot_loaded_o = ld_state_reg == LD_DONE;

	// read mux; reads while hold is high are not guaranteed to software
	wire [15:0] status_word = {12'h000, 1'b0, prot_loaded_o, bank0_busy_flag_i, access_hold_i};
	wire [15:0] rsel =
		hit_dlo  ? data_lo_reg :
		hit_dhi  ? data_hi_reg :
		hit_llo  ? loc_lo_reg :
		hit_lhi  ? loc_hi_reg :
		hit_flt  ? {{(16-F_COUNT){1'b0}}, fault_reg} :
		hit_ist  ? {{(16-F_COUNT){1'b0}}, irq_stat_reg} :
		hit_imk  ? {{(16-F_COUNT){1'b0}}, irq_mask_reg} :
		hit_sts  ? status_word :
		hit_prot ? prot_reg[idx[1:0]] : 16'h0000;

	// bus ack one cycle after request, unmapped reads zero and writes drop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			ack_reg   <= req;
			rdata_reg <= {16'h0000, rsel};
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdata_reg;

	// operand registers, 16-bit accesses on the low lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_lo_reg <= RST_DATA;
			data_hi_reg <= RST_DATA;
			loc_lo_reg  <= RST_LOC;
			loc_hi_reg  <= RST_LOC;
		end else begin
			if (wr_ok & hit_dlo) data_lo_reg <= wb_dat_i[15:0];
			if (wr_ok & hit_dhi) data_hi_reg <= wb_dat_i[15:0];
			if (wr_ok & hit_llo) loc_lo_reg <= {wb_dat_i[15:2], 2'b00};
			if (wr_ok & hit_lhi) loc_hi_reg <= {11'h000, wb_dat_i[LOC_HI_MSB:0]};
		end
	end

	// fault, interrupt and sector state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_reg    <= RST_FAULT[F_COUNT-1:0];
			pend_reg     <= '0;
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
			sector_reg   <= '0;
			busy_d_reg   <= 1'b0;
		end else begin
			fault_reg    <= fault_next;
			pend_reg     <= pend_next;
			irq_stat_reg <= ist_next;
			if (wr_ok & hit_imk) irq_mask_reg <= wb_dat_i[F_COUNT-1:0];
			sector_reg   <= sector_next;
			busy_d_reg   <= bank0_busy_flag_i;
		end
	end

	// protection loader: all active in reset, one pass over the nv copies
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ld_state_reg <= LD_IDLE;
			ld_idx_reg   <= 2'b00;
			for (int i = 0; i < PROT_REGS; i++) prot_reg[i] <= PROT_ACTIVE;
		end else begin
			case (ld_state_reg)
				LD_IDLE: ld_state_reg <= LD_REQ;
				LD_REQ: begin
					if (nv_ack_i) begin
						prot_reg[ld_idx_reg] <= nv_data_i;
						ld_idx_reg <= ld_idx_reg + 2'b01;
						if (ld_idx_reg == 2'(PROT_REGS - 1)) ld_state_reg <= LD_DONE;
					end
				end
				LD_DONE: ld_state_reg <= LD_DONE; // loaded once only
				default: ld_state_reg <= LD_IDLE;
			endcase
		end
	end

	// checks
	a_reset_data_ones: assert property (@(posedge clk_i)
		$past(rst_i) |-> program_data_o == 32'hffff_ffff) else $error("data not ones");
	a_loc_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		program_location_o[1:0] == 2'b00) else $error("address low bits set");
	// the change seen now was caused by the previous cycle, so look back one cycle
	a_fault_hold_busy: assert property (@(posedge clk_i) disable iff (rst_i)
		$past(bank0_busy_flag_i) && !$past(wr_ok && hit_flt)
		|-> $stable(fault_reg)) else $error("fault changed while busy");
	// busy high then low: the collected faults must land in the fault register
	sequence s_busy_release;
		bank0_busy_flag_i ##1 !bank0_busy_flag_i;
	endsequence
	a_publish_release: assert property (@(posedge clk_i) disable iff (rst_i)
		s_busy_release |=> ((fault_reg & $past(pend_all)) == $past(pend_all)))
		else $error("pending fault lost at busy release");
	a_abort_resume: assert property (@(posedge clk_i) disable iff (rst_i)
		ev_resume_bad_i |-> abort_o) else $error("bad resume not aborted");
	a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ok && hit_flt && !wb_dat_i[F_ERASE] && !publish[F_ERASE] |=> !fault_reg[F_ERASE])
		else $error("write zero did not clear flag");
	a_loaded_once: assert property (@(posedge clk_i) disable iff (rst_i)
		prot_loaded_o |=> prot_loaded_o) else $error("protection reloaded");
	a_seq_no_start: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_bad |-> !start_accept_o) else $error("bad setup started");
	a_seq_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
		seq_bad && !bank0_busy_flag_i |=> fault_reg[F_SEQUENCE] && fault_reg[F_WRITE])
		else $error("sequence flag missing");
	a_write_one_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ok && hit_flt && fault_reg[F_ERASE] && wb_dat_i[F_ERASE] |=> fault_reg[F_ERASE])
		else $error("write one cleared flag");
	a_prot_skip: assert property (@(posedge clk_i) disable iff (rst_i)
		(erase_enable_o & ~prot_reg[0][SECTORS-1:0]) == '0)
		else $error("protected sector erased");
	a_prot_active_load: assert property (@(posedge clk_i) disable iff (rst_i)
		!prot_loaded_o && ld_idx_reg == 2'b00 |-> write_protect_o == PROT_ACTIVE)
		else $error("protection not active");
	a_clean_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		clean_end |=> bank0_sector_status_o == '0) else $error("sectors not cleared");
	a_protect_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
		start_i && op_is_protect_i && exec_from_flash_i |-> !start_accept_o)
		else $error("protect from flash accepted");
endmodule : flash_program_operand_and_error_regs

// ### tb/tb.sv
// self-checking bench of the flash operand, fault and protection-shadow block
// assumes the package indexes, 32-bit classic wishbone and one clock at 200 MHz
`timescale 1ns/1ps
module tb;
	import flash_operand_pkg::*;
	// bus side
	logic        clk_i, rst_i, cyc, stb, we, ack;
	logic [3:0]  sel;
	logic [21:0] adr;
	logic [31:0] dat_w, dat_r, pdata;
	// engine side
	logic        busy, start, prot, exff, bad, s_acc, abrt, irq, hold;
	logic [4:0]  ev;              // erase, program, one-over-zero, resume, protected
	logic [7:0]  esel, een, sst;
	logic [20:0] ploc;
	// nv loader side
	logic        nv_ack, nv_req, loaded;
	logic [1:0]  nv_idx;
	logic [15:0] nv_dat, wp, q, dl, dh, ll, lh, v;
	logic [15:0] pv [4];
	logic [1:0]  irq_seen;
	int          n_errors, checks_done, seed, n;
	int          fpos [5] = '{F_ERASE, F_PROGRAM, F_ONEZERO, F_RESUME, F_PROTECT};

	flash_program_operand_and_error_regs dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
		.access_hold_i(hold), .bank0_busy_flag_i(busy), .start_i(start),
		.op_is_protect_i(prot), .exec_from_flash_i(exff), .setup_bad_i(bad),
		.ev_erase_fail_i(ev[0]), .ev_program_fail_i(ev[1]), .ev_one_over_zero_i(ev[2]),
		.ev_resume_bad_i(ev[3]), .ev_protected_i(ev[4]), .erase_sel_i(esel),
		.program_data_o(pdata), .program_location_o(ploc), .start_accept_o(s_acc),
		.abort_o(abrt), .erase_enable_o(een), .bank0_sector_status_o(sst),
		.nv_req_o(nv_req), .nv_idx_o(nv_idx), .nv_ack_i(nv_ack), .nv_data_i(nv_dat),
		.write_protect_o(wp), .prot_loaded_o(loaded), .irq_o(irq));

	// free-running clock, 5 ns period
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// xorshift source, fixed seed keeps runs repeatable
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction : rnd

	// location as the engine should see it, low two bits forced zero
	function automatic logic [20:0] loc_exp(logic [15:0] h, logic [15:0] l);
		return {h[4:0], l[15:2], 2'b00};
	endfunction : loc_exp

	// any fault also raises the general write flag
	function automatic logic [15:0] fault_exp(int p);
		return 16'(1 << p) | 16'(1 << F_WRITE);
	endfunction : fault_exp

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	// one classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [19:0] i, input logic [15:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		dat_w <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = dat_r[15:0];
		if (n >= 50) n_errors++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb

	task automatic rd(input logic [19:0] i, input logic [15:0] e);
		wb(1'b0, i, 16'h0000);
		chk({16'h0000, q}, {16'h0000, e});
	endtask : rd

	task automatic tick_chk(input logic g_now, input logic e);
		@(posedge clk_i);
		#1 chk({31'h0, s_acc & g_now}, {31'h0, e});
	endtask : tick_chk

	task automatic stop_test();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test

	// watchdog, tests need a few hundred cycles at most
	initial begin
		#50000;
		n_errors++;
		stop_test();
	end

	// main sequence
	initial begin
		seed = 42402;
		{cyc, stb, we, busy, start, prot, exff, bad, nv_ack, hold} = '0;
		{adr, dat_w, ev, esel, nv_dat} = '0;
		sel = 4'hf;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IDX_DATA_LO, RST_DATA);
		rd(IDX_DATA_HI, RST_DATA);
		rd(IDX_LOC_LO, RST_LOC);
		rd(IDX_FAULT, RST_FAULT);
		chk(wp, PROT_ACTIVE);
		start <= 1'b1;
		tick_chk(1'b1, 1'b0);
		start <= 1'b0;
		$display("test reset done");
		// protection copies, loader stalled longer each time
		for (int k = 0; k < PROT_REGS; k++) begin
			n = 0;
			while (nv_req !== 1'b1 && n < 100) begin
				@(posedge clk_i);
				n++;
			end
			chk(nv_idx, k);
			v = rnd();
			pv[k] = v;
			nv_dat <= v;
			nv_ack <= 1'b1;
			@(posedge clk_i);
			nv_ack <= 1'b0;
			nv_dat <= ~v;
			repeat (k + 1) @(posedge clk_i);
		end
		chk(loaded, 1'b1);
		chk(wp, pv[0]);
		for (int k = 0; k < PROT_REGS; k++) rd(IDX_PROT0 + 20'(k), pv[k]);
		v = rnd();
		esel <= v[7:0];
		@(posedge clk_i);
		#1 chk(een, esel & pv[0][7:0]);
		// hold bit is visible so software can tell when reads are valid
		hold <= 1'b1;
		rd(IDX_STATUS, 16'h0005);
		hold <= 1'b0;
		rd(IDX_STATUS, 16'h0004);
		$display("test protection done");
		// operand registers, first pass sets address bits 20:2
		for (int k = 0; k < 5; k++) begin
			dl = rnd();
			dh = rnd();
			ll = (k == 0) ? 16'hffff : rnd();
			lh = (k == 0) ? 16'hffff : rnd();
			wb(1'b1, IDX_DATA_LO, dl);
			wb(1'b1, IDX_DATA_HI, dh);
			wb(1'b1, IDX_LOC_LO, ll);
			wb(1'b1, IDX_LOC_HI, lh);
			rd(IDX_DATA_LO, dl);
			rd(IDX_DATA_HI, dh);
			chk(pdata, {dh, dl});
			chk(ploc, loc_exp(lh, ll));
		end
		sel <= 4'hc;
		wb(1'b1, IDX_DATA_LO, ~dl);
		sel <= 4'hf;
		rd(IDX_DATA_LO, dl);
		wb(1'b1, 20'h0_0001, 16'h5555);
		rd(20'h0_0001, 16'h0000);
		$display("test registers done");
		// start qualifiers
		bad <= 1'b1;
		start <= 1'b1;
		tick_chk(1'b1, 1'b0);
		bad <= 1'b0;
		prot <= 1'b1;
		exff <= 1'b1;
		tick_chk(1'b1, 1'b0);
		exff <= 1'b0;
		tick_chk(1'b1, 1'b1);
		start <= 1'b0;
		prot <= 1'b0;
		rd(IDX_FAULT, fault_exp(F_SEQUENCE));
		wb(1'b1, IDX_FAULT, 16'h0000);
		rd(IDX_FAULT, 16'h0000);
		// fault held back while the bank is busy
		busy <= 1'b1;
		ev <= 5'b00010;
		@(posedge clk_i);
		ev <= 5'b00000;
		rd(IDX_FAULT, 16'h0000);
		busy <= 1'b0;
		repeat (2) @(posedge clk_i);
		rd(IDX_FAULT, fault_exp(F_PROGRAM));
		chk(sst, esel);
		// a clean busy pulse must clear the sector status
		busy <= 1'b1;
		@(posedge clk_i);
		busy <= 1'b0;
		@(posedge clk_i);
		#1 chk(sst, 8'h00);
		// each event alone, then write one keeps and write zero clears
		for (int k = 0; k < 5; k++) begin
			wb(1'b1, IDX_FAULT, 16'h0000);
			ev <= 5'(1 << k);
			@(posedge clk_i);
			#1 chk(abrt, k == 3);
			ev <= 5'b00000;
			rd(IDX_FAULT, fault_exp(fpos[k]));
			wb(1'b1, IDX_FAULT, 16'hffff);
			rd(IDX_FAULT, fault_exp(fpos[k]));
		end
		$display("test faults done");
		// interrupt follows the mask, then clears by writing ones
		wb(1'b1, IDX_IRQ_MASK, 16'hffff);
		irq_seen[0] = irq;
		wb(1'b1, IDX_IRQ_MASK, 16'h0000);
		irq_seen[1] = irq;
		chk(irq_seen[0] ^ irq_seen[1], 1'b1);
		wb(1'b1, IDX_IRQ_STAT, 16'hffff);
		wb(1'b1, IDX_IRQ_MASK, 16'hffff);
		@(posedge clk_i);
		#1 chk(irq, 1'b0);
		$display("test interrupt done");
		stop_test();
	end
endmodule : tb
